// file: design/sabd_core.sv
`timescale 1ns/1ps
`default_nettype none

module sabd_core #(
  parameter int DIV_W = 16
) (
  // clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        resetn_i,
  // register port
  input  wire logic [sabd_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]                  reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [7:0]                  reg_rdata_o,
  // serial line
  input  wire logic                        rx_i,
  // normal receiver
  input  wire logic [7:0]                  rx_byte_i,
  input  wire logic                        rx_byte_valid_i,
  output logic                             rx_hold_o,
  // baud generator settings
  output logic      [DIV_W-1:0]            baud_divisor_o,
  output logic                             wide_divider_select_o,
  output logic                             high_speed_select_o,
  // interrupt
  output logic                             irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // parameter check

  if (DIV_W != 16) begin : g_bad_width
    $error("divisor width must be 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  sabd_presc_if presc ();

  sabd_pkg::sabd_state_t state_q;
  sabd_pkg::sabd_state_t state_d;

  logic             rx_meta_q;
  logic             rx_sync_q;
  logic             rx_prev_q;
  logic             rx_rise;
  logic             rx_fall;

  logic             autobaud_enable_q;
  logic             wake_on_break_enable_q;
  logic             wide_divider_select_q;
  logic             high_speed_select_q;
  logic             autobaud_overflow_q;
  logic [DIV_W-1:0] divisor_q;
  logic [2:0]       edge_cnt_q;
  logic [7:0]       receive_buffer_q;
  logic [7:0]       flags_q;
  logic [7:0]       enables_q;
  logic [7:0]       rdata_q;

  logic             active;
  logic             first_rise;
  logic             last_rise;
  logic             cal_done;
  logic             cnt_wrap;
  logic             wr_bc;
  logic             wr_lo;
  logic             wr_hi;
  logic             wr_txc;
  logic             wr_en;
  logic             wr_clr;
  logic             rd_rxbuf;
  logic [7:0]       flag_set;
  logic [7:0]       flag_clr;

  function automatic logic hit(
    input logic                        strobe,
    input logic [sabd_pkg::ADDR_W-1:0] addr,
    input logic [sabd_pkg::ADDR_W-1:0] off
  );
    hit = strobe && (addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // receive line synchroniser and edge detect

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_meta_q <= rx_i;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
    end
  end

  assign rx_rise = rx_sync_q && !rx_prev_q;
  assign rx_fall = !rx_sync_q && rx_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // write decode and receive buffer read decode

  assign wr_bc    = hit(reg_wr_i, reg_addr_i, sabd_pkg::OFF_BAUD_CONTROL);
  assign wr_lo    = hit(reg_wr_i, reg_addr_i, sabd_pkg::OFF_DIVISOR_LOW);
  assign wr_hi    = hit(reg_wr_i, reg_addr_i, sabd_pkg::OFF_DIVISOR_HIGH);
  assign wr_txc   = hit(reg_wr_i, reg_addr_i, sabd_pkg::OFF_TX_CONTROL);
  assign wr_en    = hit(reg_wr_i, reg_addr_i, sabd_pkg::OFF_ENABLES);
  assign wr_clr   = hit(reg_wr_i, reg_addr_i, sabd_pkg::OFF_FLAG_CLEAR);
  assign rd_rxbuf = hit(reg_rd_i, reg_addr_i, sabd_pkg::OFF_RECEIVE_BUFFER);

  ////////////////////////////////////////////////////////////////////////////
  // calibration sequence

  assign active     = (state_q != sabd_pkg::ST_IDLE);
  assign first_rise = (state_q == sabd_pkg::ST_EDGE1) && rx_rise;
  assign last_rise  = (state_q == sabd_pkg::ST_COUNT) && rx_rise
                      && (edge_cnt_q == sabd_pkg::EDGE_LAST - 3'h1);
  assign cal_done   = last_rise && autobaud_enable_q;
  assign cnt_wrap   = (state_q == sabd_pkg::ST_COUNT) && presc.tick
                      && !rx_rise && (&divisor_q);

  always_comb begin
    state_d = state_q;
    if (!autobaud_enable_q) begin
      state_d = sabd_pkg::ST_IDLE;
    end else begin
      case (state_q)
        sabd_pkg::ST_IDLE: begin
          if (wake_on_break_enable_q) begin
            state_d = sabd_pkg::ST_BREAK;
          end else begin
            state_d = sabd_pkg::ST_START;
          end
        end
        sabd_pkg::ST_BREAK: begin
          if (rx_rise) begin
            state_d = sabd_pkg::ST_START;
          end
        end
        sabd_pkg::ST_START: begin
          if (rx_fall) begin
            state_d = sabd_pkg::ST_EDGE1;
          end
        end
        sabd_pkg::ST_EDGE1: begin
          if (rx_rise) begin
            state_d = sabd_pkg::ST_COUNT;
          end
        end
        sabd_pkg::ST_COUNT: begin
          if (last_rise) begin
            state_d = sabd_pkg::ST_IDLE;
          end
        end
        default: begin
          state_d = sabd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= sabd_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // rising edges seen since the first one after the start bit
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      edge_cnt_q <= 3'h0;
    end else if (first_rise) begin
      edge_cnt_q <= 3'h1;
    end else if (state_q == sabd_pkg::ST_COUNT && rx_rise) begin
      edge_cnt_q <= edge_cnt_q + 3'h1;
    end else if (!active) begin
      edge_cnt_q <= 3'h0;
    end
  end

  assign presc.run      = (state_q == sabd_pkg::ST_COUNT);
  assign presc.wide_sel = wide_divider_select_q;
  assign presc.high_spd = high_speed_select_q;

  sabd_prescaler u_presc (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .presc     (presc.gen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // divisor pair: software register, calibration counter while counting

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      divisor_q <= sabd_pkg::RST_DIVISOR;
    end else if (first_rise) begin
      divisor_q <= sabd_pkg::CAL_START;
    end else if (state_q == sabd_pkg::ST_COUNT) begin
      if (presc.tick && !rx_rise) begin
        divisor_q <= divisor_q + 16'h0001;
      end
    end else begin
      if (wr_lo) begin
        divisor_q[7:0] <= reg_wdata_i;
      end
      if (wr_hi) begin
        divisor_q[15:8] <= reg_wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control bits

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      autobaud_enable_q <= 1'b0;
    end else if (cal_done) begin
      autobaud_enable_q <= 1'b0;
    end else if (wr_bc) begin
      autobaud_enable_q <= reg_wdata_i[sabd_pkg::BC_AUTOBAUD];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_on_break_enable_q <= 1'b0;
      wide_divider_select_q  <= 1'b0;
    end else if (wr_bc) begin
      wake_on_break_enable_q <= reg_wdata_i[sabd_pkg::BC_WAKE];
      wide_divider_select_q  <= reg_wdata_i[sabd_pkg::BC_WIDE];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      high_speed_select_q <= 1'b0;
    end else if (wr_txc) begin
      high_speed_select_q <= reg_wdata_i[sabd_pkg::TXC_HIGH_SPD];
    end
  end

  // counter wrap is sticky; software writes zero to clear, wrap wins
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      autobaud_overflow_q <= 1'b0;
    end else if (cnt_wrap) begin
      autobaud_overflow_q <= 1'b1;
    end else if (wr_bc && !reg_wdata_i[sabd_pkg::BC_OVERFLOW]) begin
      autobaud_overflow_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive buffer from the normal receiver, ignored while held

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      receive_buffer_q <= sabd_pkg::RST_BYTE;
    end else if (rx_byte_valid_i && !active) begin
      receive_buffer_q <= rx_byte_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags, enables and interrupt

  always_comb begin
    flag_set = 8'h00;
    flag_clr = 8'h00;
    flag_set[sabd_pkg::FLG_RECEIVE]  = cal_done
                                       || (rx_byte_valid_i && !active);
    flag_set[sabd_pkg::FLG_OVERFLOW] = cnt_wrap;
    if (wr_clr) begin
      flag_clr = reg_wdata_i;
    end
    flag_clr[sabd_pkg::FLG_RECEIVE] = flag_clr[sabd_pkg::FLG_RECEIVE]
                                      || rd_rxbuf;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          flags_q[gi] <= 1'b0;
        end else if (flag_set[gi]) begin
          flags_q[gi] <= 1'b1;
        end else if (flag_clr[gi]) begin
          flags_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enables_q <= sabd_pkg::RST_BYTE;
    end else if (wr_en) begin
      enables_q <= reg_wdata_i;
    end
  end

  assign irq_o = |(flags_q & enables_q);

  ////////////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the strobe, only in that cycle

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 8'h00;
    end else if (!reg_rd_i) begin
      rdata_q <= 8'h00;
    end else begin
      case (reg_addr_i)
        sabd_pkg::OFF_BAUD_CONTROL: begin
          rdata_q                        <= 8'h00;
          rdata_q[sabd_pkg::BC_OVERFLOW] <= autobaud_overflow_q;
          rdata_q[sabd_pkg::BC_RX_IDLE]  <= !active;
          rdata_q[sabd_pkg::BC_WIDE]     <= wide_divider_select_q;
          rdata_q[sabd_pkg::BC_WAKE]     <= wake_on_break_enable_q;
          rdata_q[sabd_pkg::BC_AUTOBAUD] <= autobaud_enable_q;
        end
        sabd_pkg::OFF_RECEIVE_BUFFER: begin
          rdata_q <= receive_buffer_q;
        end
        sabd_pkg::OFF_DIVISOR_LOW: begin
          rdata_q <= divisor_q[7:0];
        end
        sabd_pkg::OFF_DIVISOR_HIGH: begin
          rdata_q <= divisor_q[15:8];
        end
        sabd_pkg::OFF_TX_CONTROL: begin
          rdata_q                         <= 8'h00;
          rdata_q[sabd_pkg::TXC_HIGH_SPD] <= high_speed_select_q;
        end
        sabd_pkg::OFF_FLAGS: begin
          rdata_q <= flags_q;
        end
        sabd_pkg::OFF_ENABLES: begin
          rdata_q <= enables_q;
        end
        default: begin
          rdata_q <= 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata_o           = rdata_q;
  assign rx_hold_o             = active;
  assign baud_divisor_o        = divisor_q;
  assign wide_divider_select_o = wide_divider_select_q;
  assign high_speed_select_o   = high_speed_select_q;

endmodule

`default_nettype wire

// file: design/sabd_pkg.sv
`default_nettype none

package sabd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (index on the plain register port)
  localparam int          ADDR_W             = 3;
  localparam logic [2:0]  OFF_BAUD_CONTROL   = 3'h0;
  localparam logic [2:0]  OFF_RECEIVE_BUFFER = 3'h1;
  localparam logic [2:0]  OFF_DIVISOR_LOW    = 3'h2;
  localparam logic [2:0]  OFF_DIVISOR_HIGH   = 3'h3;
  localparam logic [2:0]  OFF_TX_CONTROL     = 3'h4;
  localparam logic [2:0]  OFF_FLAGS          = 3'h5;
  localparam logic [2:0]  OFF_ENABLES        = 3'h6;
  localparam logic [2:0]  OFF_FLAG_CLEAR     = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int BC_OVERFLOW  = 7;
  localparam int BC_RX_IDLE   = 6;
  localparam int BC_WIDE      = 3;
  localparam int BC_WAKE      = 1;
  localparam int BC_AUTOBAUD  = 0;
  localparam int TXC_HIGH_SPD = 2;
  localparam int FLG_RECEIVE  = 5;
  localparam int FLG_OVERFLOW = 0;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_DIVISOR = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // calibration timing: prescaler terminal counts (divide by 512/128/32)
  localparam int          PRE_W        = 9;
  localparam logic [8:0]  PRE_LIM_SLOW = 9'h1ff;
  localparam logic [8:0]  PRE_LIM_MID  = 9'h07f;
  localparam logic [8:0]  PRE_LIM_FAST = 9'h01f;
  localparam logic [15:0] CAL_START    = 16'h0001;
  localparam logic [2:0]  EDGE_LAST    = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // calibration sequence states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_BREAK = 5'b00010,
    ST_START = 5'b00100,
    ST_EDGE1 = 5'b01000,
    ST_COUNT = 5'b10000
  } sabd_state_t;

endpackage

`default_nettype wire

// file: design/sabd_presc_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sabd_presc_if;
  logic run;
  logic wide_sel;
  logic high_spd;
  logic tick;

  modport ctrl (output run, output wide_sel, output high_spd, input tick);
  modport gen  (input run, input wide_sel, input high_spd, output tick);
endinterface

`default_nettype wire

// file: design/sabd_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module sabd_prescaler (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  // control and tick
  sabd_presc_if.gen       presc
);

  logic [sabd_pkg::PRE_W-1:0] cnt_q;
  logic [sabd_pkg::PRE_W-1:0] lim;

  function automatic logic [sabd_pkg::PRE_W-1:0] pre_limit(
    input logic wide,
    input logic hs
  );
    case ({wide, hs})
      2'b00:   pre_limit = sabd_pkg::PRE_LIM_SLOW;
      2'b11:   pre_limit = sabd_pkg::PRE_LIM_FAST;
      default: pre_limit = sabd_pkg::PRE_LIM_MID;
    endcase
  endfunction

  assign lim = pre_limit(presc.wide_sel, presc.high_spd);

  // one tick per eight base clocks of the selected rate
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
    end else if (!presc.run || cnt_q == lim) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign presc.tick = presc.run && (cnt_q == lim);

endmodule

`default_nettype wire

// file: tb/sabd_core_sva.sv
`timescale 1ns/1ps
`default_nettype none

module sabd_core_sva #(
  parameter int DIV_W = 16
) (
  // clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        resetn_i,
  // register port
  input  wire logic [sabd_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]                  reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  input  wire logic [7:0]                  reg_rdata_o,
  // serial line and receiver
  input  wire logic                        rx_i,
  input  wire logic [7:0]                  rx_byte_i,
  input  wire logic                        rx_byte_valid_i,
  input  wire logic                        rx_hold_o,
  // baud settings and interrupt
  input  wire logic [DIV_W-1:0]            baud_divisor_o,
  input  wire logic                        wide_divider_select_o,
  input  wire logic                        high_speed_select_o,
  input  wire logic                        irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  logic [DIV_W-1:0] div_prev_q;
  logic [11:0]      gap_q;
  logic [11:0]      tick_n;
  logic             chg;
  logic             bc_wr;

  assign chg    = baud_divisor_o != div_prev_q;
  assign bc_wr  = reg_wr_i && reg_addr_i == sabd_pkg::OFF_BAUD_CONTROL;
  assign tick_n = (wide_divider_select_o && high_speed_select_o) ? 12'h020 :
                  (wide_divider_select_o || high_speed_select_o) ? 12'h080 :
                  12'h200;

  // cycles between successive divisor changes
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_prev_q <= '0;
      gap_q      <= 12'h000;
    end else begin
      div_prev_q <= baud_divisor_o;
      gap_q      <= chg ? 12'h001 : gap_q + {11'h000, gap_q != 12'hfff};
    end
  end

  property p_hold_start;
    bc_wr && reg_wdata_i[0] && !rx_hold_o |-> ##2 rx_hold_o;
  endproperty
  a_hold_start: assert property (p_hold_start)
    else $error("calibration did not start");
  property p_abort;
    bc_wr && !reg_wdata_i[0] && rx_hold_o |-> ##2 !rx_hold_o && $stable(irq_o);
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort did not return to idle cleanly");
  property p_end_on_rise;
    $fell(rx_hold_o) && !$past(bc_wr, 2) |->
      ($past(rx_i, 2) && !$past(rx_i, 3)) ||
      ($past(rx_i, 3) && !$past(rx_i, 4)) ||
      ($past(rx_i, 4) && !$past(rx_i, 5));
  endproperty
  a_end_on_rise: assert property (p_end_on_rise)
    else $error("calibration ended without a receive rise");
  property p_irq_cause;
    $rose(irq_o) |-> $fell(rx_hold_o) || $past(reg_wr_i) || rx_hold_o ||
      $past(rx_byte_valid_i);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt rose without an event");
  property p_div_quiet;
    !rx_hold_o && !$past(rx_hold_o) && !$past(reg_wr_i) &&
      !$past(reg_wr_i, 2) |-> $stable(baud_divisor_o);
  endproperty
  a_div_quiet: assert property (p_div_quiet)
    else $error("divisor moved outside calibration");
  property p_div_step;
    chg && rx_hold_o && $past(rx_hold_o) && !$past(reg_wr_i) |->
      baud_divisor_o == div_prev_q + 1'b1 || baud_divisor_o == 16'h0001;
  endproperty
  a_div_step: assert property (p_div_step)
    else $error("divisor did not count up from one");
  property p_tick_gap;
    chg && rx_hold_o && div_prev_q > 1 && baud_divisor_o != 16'h0001 &&
      !$past(reg_wr_i) |-> gap_q == tick_n || gap_q == {tick_n[10:0], 1'b0};
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("divisor counted at the wrong rate");
  property p_rdata_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its cycle");

  c_done: cover property ($fell(rx_hold_o) && !$past(bc_wr, 2));
  c_abort: cover property (bc_wr && !reg_wdata_i[0] && rx_hold_o);
  c_irq: cover property ($rose(irq_o));
endmodule

`default_nettype wire

// file: tb/sabd_remote_tx.sv
`timescale 1ns/1ps
`default_nettype none

module sabd_remote_tx (
  // clock
  input  wire logic sys_clk_i,
  // serial line towards the block
  output logic      rx_o
);
  localparam logic [7:0] SYNC_CHAR = 8'h55;

  initial rx_o = 1'b1;

  task automatic hold_line(input logic lvl, input int cyc);
    @(posedge sys_clk_i);
    rx_o <= lvl;
    repeat (cyc - 1) @(posedge sys_clk_i);
  endtask

  // optional break, then the first nbits of start, data lsb first, stop; line idles high
  task automatic send(input int bt, input logic brk, input int nbits);
    logic [9:0] frame;
    frame = {1'b1, SYNC_CHAR, 1'b0};
    if (brk) begin
      hold_line(1'b0, 13 * bt);
      hold_line(1'b1, bt);
    end
    for (int i = 0; i < nbits; i++) begin
      hold_line(frame[i], bt);
    end
  endtask
endmodule

`default_nettype wire

// file: tb/serial_autobaud_detect_test.sv
`timescale 1ns/1ps
`default_nettype none

module serial_autobaud_detect_test;
  logic        sys_clk_i       = 1'b0;
  logic        resetn_i        = 1'b0;
  logic [2:0]  reg_addr_i      = 3'h0;
  logic [7:0]  reg_wdata_i     = 8'h00;
  logic        reg_wr_i        = 1'b0;
  logic        reg_rd_i        = 1'b0;
  logic [7:0]  rx_byte_i       = 8'h00;
  logic        rx_byte_valid_i = 1'b0;
  logic [7:0]  reg_rdata_o;
  logic        rx_i;
  logic        rx_hold_o;
  logic [15:0] baud_divisor_o;
  logic        wide_o;
  logic        high_o;
  logic        irq_o;
  int          miscompares     = 0;
  int          checks_done     = 0;
  int          seed            = 40410;
  logic [7:0]  v;
  logic [7:0]  keep;

  always #5 sys_clk_i = ~sys_clk_i;

  sabd_core #(.DIV_W(16)) DUT (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .rx_i(rx_i), .rx_byte_i(rx_byte_i),
    .rx_byte_valid_i(rx_byte_valid_i), .rx_hold_o(rx_hold_o),
    .baud_divisor_o(baud_divisor_o), .wide_divider_select_o(wide_o),
    .high_speed_select_o(high_o), .irq_o(irq_o));

  sabd_remote_tx rtx (.sys_clk_i(sys_clk_i), .rx_o(rx_i));

  ////////////////////////////////////////////////////////////////////////////
  function automatic int tick_clocks(input logic [1:0] m);
    return (m == 2'b11) ? 32 : ((m == 2'b00) ? 512 : 128);
  endfunction
  // half a tick of offset keeps ticks clear of the receive rises
  function automatic int bit_clocks(input logic [1:0] m, input int d);
    return tick_clocks(m) / 8 * d + tick_clocks(m) / 16;
  endfunction
  function automatic logic [15:0] exp_div(input int d);
    return sabd_pkg::CAL_START + 16'(d);
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask
  task automatic pulse(input logic [7:0] b);
    @(posedge sys_clk_i);
    rx_byte_i       <= b;
    rx_byte_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    rx_byte_valid_i <= 1'b0;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 40 && rx_hold_o !== 1'b0; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    if (rx_hold_o !== 1'b0) begin
      miscompares++;
      $display("BAD %0t calibration never ended", $time);
      test_done();
    end
  endtask

  task automatic calibrate(input logic [1:0] m, input int d, input logic brk,
                           input logic ie);
    wr(sabd_pkg::OFF_ENABLES, {2'h0, ie, 5'h00});
    wr(sabd_pkg::OFF_TX_CONTROL, {5'h00, m[0], 2'h0});
    wr(sabd_pkg::OFF_BAUD_CONTROL, {4'h0, m[1], 1'b0, brk, 1'b1});
    @(posedge sys_clk_i);
    #1;
    check(rx_hold_o, 1'b1, "hold");
    rtx.send(bit_clocks(m, d), brk, 10);
    wait_idle();
    check(baud_divisor_o, exp_div(d), "divisor");
    check({wide_o, high_o}, m, "mode");
    rd(sabd_pkg::OFF_DIVISOR_HIGH, v);
    check(v, 8'h00, "high byte");
    rd(sabd_pkg::OFF_BAUD_CONTROL, v);
    check(v, {4'h4, m[1], 1'b0, brk, 1'b0}, "control");
    rd(sabd_pkg::OFF_FLAGS, v);
    check(v, 8'h20, "flag");
    check(irq_o, ie, "irq");
    if (ie) rd(sabd_pkg::OFF_RECEIVE_BUFFER, v);
    else wr(sabd_pkg::OFF_FLAG_CLEAR, 8'h20);
    rd(sabd_pkg::OFF_FLAGS, v);
    check({irq_o, v}, 9'h000, "cleared");
    $display("test calibrate mode %0d done", m);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), v);
      check(v, (a == 0) ? 8'h40 : 8'h00, "reset value");
    end
    keep = 8'($random(seed));
    v = 8'($random(seed));
    wr(sabd_pkg::OFF_DIVISOR_LOW, v);
    wr(sabd_pkg::OFF_DIVISOR_HIGH, keep);
    wr(sabd_pkg::OFF_RECEIVE_BUFFER, 8'hff);
    wr(sabd_pkg::OFF_FLAGS, 8'hff);
    check(baud_divisor_o, {keep, v}, "divisor write");
    rd(sabd_pkg::OFF_FLAGS, v);
    check(v, 8'h00, "read only flags");
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      calibrate(2'(m), 2 + {$random(seed)} % 8, 1'b0, m[0]);
    end
    calibrate(2'b11, 6, 1'b1, 1'b1);
    // four bits of a character, then software drops the enable
    keep = 8'($random(seed));
    pulse(keep);
    rd(sabd_pkg::OFF_RECEIVE_BUFFER, v);
    check(v, keep, "receive buffer");
    wr(sabd_pkg::OFF_ENABLES, 8'h20);
    wr(sabd_pkg::OFF_BAUD_CONTROL, 8'h01);
    rtx.send(bit_clocks(2'b11, 4), 1'b0, 4);
    pulse(~keep);
    wr(sabd_pkg::OFF_BAUD_CONTROL, 8'h00);
    @(posedge sys_clk_i);
    #1;
    check({rx_hold_o, irq_o}, 2'b00, "abort");
    rd(sabd_pkg::OFF_FLAGS, v);
    check(v, 8'h00, "abort flags");
    rd(sabd_pkg::OFF_RECEIVE_BUFFER, v);
    check(v, keep, "held receiver");
    $display("test abort done");
    test_done();
  end
endmodule

bind sabd_core sabd_core_sva #(.DIV_W(DIV_W)) u_sva (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .rx_i(rx_i), .rx_byte_i(rx_byte_i),
  .rx_byte_valid_i(rx_byte_valid_i), .rx_hold_o(rx_hold_o),
  .baud_divisor_o(baud_divisor_o),
  .wide_divider_select_o(wide_divider_select_o),
  .high_speed_select_o(high_speed_select_o), .irq_o(irq_o));

`default_nettype wire
